// file: hw/lemc_core.sv
/*
 * Line event monitor control: hook release ramp, tone detection flags,
 * on-hook line monitor, ring threshold flags and caller-ID squelch.
 * Assumes an APB master on the system clock, comparator and level pins
 * from the line side (asynchronous), and converter samples on i_clk_sys.
 */
`timescale 1ns/1ns
module lemc_core
    import lemc_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_line_over,
    input  wire logic        i_supply_sag,
    input  wire logic        i_overload_level,
    input  wire logic        i_line_present,
    input  wire logic [15:0] i_ring_sample,
    input  wire logic [3:0]  i_loop_meter,
    input  wire logic        i_bit_clk,
    input  wire logic        i_sync,
    output logic             o_sdata_in,
    output logic      [7:0]  o_loop_drive,
    output logic             o_dc_release,
    output logic             o_monitor_power,
    output logic             o_coupling_reset,
    output logic             o_ring_detect
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [CTRL_W-1:0]     ctrl_q;
    logic [14:0]           thr_q;
    logic [PIN_W-1:0]      pin_meta_q, pin_q;
    logic                  ovr_q, td_q, rpos_q, rneg_q;
    logic [3:0]            lcode_q;
    logic [15:0]           mon_q;
    logic [RAMP_CNT_W-1:0] step_cnt_q;
    logic                  wr_en, rd_setup, wr_stat;
    logic                  ovr_set, td_set, ovr_clr, td_clr;
    logic signed [15:0]    samp, thr_pos, thr_neg;
    lemc_word_if           word_if ();

    // True for every mapped word address
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STAT) ||
                      (a == ADDR_MON)  || (a == ADDR_THR);
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Comparator pins come from the isolated line side, unrelated to this clock
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pin_meta_q <= '0;
            pin_q      <= '0;
        end else begin
            pin_meta_q <= {i_line_present, i_overload_level, i_supply_sag, i_line_over};
            pin_q      <= pin_meta_q;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero wait states: read data is caught in the setup cycle
    assign wr_en     = i_psel & i_penable & i_pwrite & addr_mapped(i_paddr);
    assign rd_setup  = i_psel & ~i_penable & ~i_pwrite;
    assign wr_stat   = wr_en & (i_paddr == ADDR_STAT);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_mapped(i_paddr);

    // Read mux, unmapped addresses read as zero
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= 32'h0000_0000;
            unique case (i_paddr)
                ADDR_CTRL: o_prdata[CTRL_W-1:0] <= ctrl_q;
                ADDR_STAT: begin
                    o_prdata[STAT_OVR]  <= ovr_q;
                    o_prdata[STAT_TD]   <= td_q;
                    o_prdata[STAT_OVL]  <= pin_q[PIN_OVL];
                    o_prdata[STAT_RPOS] <= rpos_q;
                    o_prdata[STAT_RNEG] <= rneg_q;
                    o_prdata[STAT_RDET] <= o_ring_detect;
                    o_prdata[STAT_LCODE +: 4] <= lcode_q;
                end
                ADDR_MON:  o_prdata[15:0] <= mon_q;
                ADDR_THR:  o_prdata[14:0] <= thr_q;
                default:   o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control and threshold registers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctrl_q <= CTRL_RST;
            thr_q  <= THR_RST;
        end else if (wr_en) begin
            if (i_paddr == ADDR_CTRL) begin
                ctrl_q <= i_pwdata[CTRL_W-1:0];
            end
            if (i_paddr == ADDR_THR) begin
                thr_q <= i_pwdata[14:0];
            end
        end
    end

    // ************************************************************
    // Tone detection flags
    // ************************************************************
    assign ovr_set = pin_q[PIN_OVER];
    assign td_set  = pin_q[PIN_SAG] & ctrl_q[CTRL_TDEN];
    assign ovr_clr = wr_stat & ~i_pwdata[STAT_OVR];
    assign td_clr  = wr_stat & ~i_pwdata[STAT_TD];

    // Sticky until written zero; a set in the same cycle beats the clear
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ovr_q <= 1'b0;
            td_q  <= 1'b0;
        end else begin
            ovr_q <= ovr_set | (ovr_q & ~ovr_clr);
            td_q  <= td_set | (td_q & ~td_clr);
        end
    end

    // Termination release follows the tone flag; software ends it by clearing
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_dc_release <= 1'b0;
        end else begin
            o_dc_release <= td_q;
        end
    end

    // ************************************************************
    // Hook release ramp
    // ************************************************************
    // A sudden cut into an inductive feed spikes the line, so step down
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_loop_drive <= DRIVE_OFF;
            step_cnt_q   <= '0;
        end else if (ctrl_q[CTRL_HOOK]) begin
            o_loop_drive <= DRIVE_FULL;
            step_cnt_q   <= '0;
        end else if (!ctrl_q[CTRL_RAMP]) begin
            o_loop_drive <= DRIVE_OFF;
            step_cnt_q   <= '0;
        end else if (o_loop_drive != DRIVE_OFF) begin
            if (step_cnt_q == RAMP_CNT_W'(RAMP_STEP_CYC - 1)) begin
                o_loop_drive <= o_loop_drive - 8'h01;
                step_cnt_q   <= '0;
            end else begin
                step_cnt_q <= step_cnt_q + RAMP_CNT_W'(1);
            end
        end
    end

    // ************************************************************
    // Ring thresholds and detector
    // ************************************************************
    assign samp    = i_ring_sample;
    assign thr_pos = {1'b0, thr_q};
    assign thr_neg = -thr_pos;

    // A reversal shifts the level past one threshold just as a ring would
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rpos_q        <= 1'b0;
            rneg_q        <= 1'b0;
            o_ring_detect <= 1'b0;
        end else begin
            rpos_q        <= samp > thr_pos;
            rneg_q        <= samp < thr_neg;
            o_ring_detect <= rpos_q | (ctrl_q[CTRL_FW] & rneg_q);
        end
    end

    // Squelch drives the coupling reset directly, width is software's job
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_coupling_reset <= 1'b0;
        end else begin
            o_coupling_reset <= ctrl_q[CTRL_SQL];
        end
    end

    // ************************************************************
    // On-hook line monitor
    // ************************************************************
    // With no line the converter sinks to full negative scale
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_monitor_power <= 1'b0;
            mon_q           <= 16'h0000;
            lcode_q         <= LCODE_NONE;
        end else begin
            o_monitor_power <= ctrl_q[CTRL_MON];
            if (!ctrl_q[CTRL_MON]) begin
                mon_q   <= 16'h0000;
                lcode_q <= i_loop_meter;
            end else if (pin_q[PIN_LINE]) begin
                mon_q   <= i_ring_sample;
                lcode_q <= LCODE_LINE;
            end else begin
                mon_q   <= NEG_FULL;
                lcode_q <= LCODE_NONE;
            end
        end
    end

    assign word_if.word  = mon_q;
    assign word_if.valid = o_monitor_power;

    // Link serializer for the data-in pin
    lemc_link_tx u_link (
        .i_clk_sys  (i_clk_sys),
        .i_srst     (i_srst),
        .i_bit_clk  (i_bit_clk),
        .i_sync     (i_sync),
        .word_if    (word_if.snk),
        .o_sdata_in (o_sdata_in)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    flag_sticky_a : assert property (ovr_q && !ovr_clr |=> ovr_q)
        else $error("overrange flag dropped without a clearing write");
    set_wins_a : assert property (td_set && td_clr |=> td_q)
        else $error("tone flag lost to a clear in the set cycle");
    tone_gate_a : assert property (!ctrl_q[CTRL_TDEN] && !td_q |=> !td_q)
        else $error("tone flag raised while detection disabled");
    overrange_a : assert property ($rose(pin_q[PIN_OVER]) |=> ovr_q)
        else $error("overrange flag not set after synchronised pin");
    release_a : assert property (td_q |=> o_dc_release)
        else $error("termination not released under tone flag");
    ramp_down_a : assert property (!ctrl_q[CTRL_HOOK] && ctrl_q[CTRL_RAMP]
        && $past(ctrl_q[CTRL_HOOK]) && o_loop_drive == DRIVE_FULL
        |=> o_loop_drive == DRIVE_FULL)
        else $error("loop drive cut at once with ramp selected");
    line_code_a : assert property (ctrl_q[CTRL_MON] && pin_q[PIN_LINE]
        |=> lcode_q == LCODE_LINE)
        else $error("loop code not 1111b with line present");
    no_line_a : assert property (ctrl_q[CTRL_MON] && !pin_q[PIN_LINE]
        |=> mon_q == NEG_FULL && lcode_q == LCODE_NONE)
        else $error("monitor word not at negative full scale");
    ring_pos_a : assert property (samp > thr_pos |=> ##1 o_ring_detect)
        else $error("positive ring excursion not detected");
    // Mode must stay half-wave into the cycle the detector combines the flags
    halfwave_a : assert property (!ctrl_q[CTRL_FW] && samp < thr_neg
        ##1 !ctrl_q[CTRL_FW] |=> !o_ring_detect)
        else $error("negative excursion detected in half-wave mode");
    squelch_a : assert property ($rose(ctrl_q[CTRL_SQL]) |=> o_coupling_reset)
        else $error("coupling reset did not follow squelch");
    power_a : assert property ($rose(ctrl_q[CTRL_MON]) |=> o_monitor_power)
        else $error("converter not powered by monitor enable");

    cover property ($rose(td_q) ##[1:20] o_dc_release);
    cover property (ctrl_q[CTRL_MON] && pin_q[PIN_LINE] ##1 lcode_q == LCODE_LINE);
    cover property (ctrl_q[CTRL_FW] && rneg_q ##1 o_ring_detect);
    cover property (ctrl_q[CTRL_RAMP] && o_loop_drive == 8'h01 ##[1:1000] o_loop_drive == 8'h00);

endmodule

// file: hw/lemc_pkg.sv
/*
 * Shared constants and types of the line event monitor control block.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
package lemc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS        = 10;
    localparam int RAMP_STEP_NS  = 10000;                   // Time per drive step
    localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAMP_CNT_W    = 10;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MON  = 8'h08;
    localparam logic [7:0] ADDR_THR  = 8'h0c;

    // Control register fields
    localparam int CTRL_RAMP  = 0;                          // hook_release_ramp
    localparam int CTRL_TDEN  = 1;                          // tone_detect_enable
    localparam int CTRL_SQL   = 2;                          // ring_coupling_squelch
    localparam int CTRL_FW    = 3;                          // ring_fullwave_select
    localparam int CTRL_MON   = 4;                          // line_one_monitor_enable
    localparam int CTRL_HOOK  = 5;                          // off-hook request
    localparam int CTRL_W     = 6;

    // Status register fields
    localparam int STAT_OVR   = 0;                          // adc_overrange_flag
    localparam int STAT_TD    = 1;                          // tone_detect_flag
    localparam int STAT_OVL   = 2;                          // overload_level_flag
    localparam int STAT_RPOS  = 3;                          // ring_positive_flag
    localparam int STAT_RNEG  = 4;                          // ring_negative_flag
    localparam int STAT_RDET  = 5;                          // ring detector output
    localparam int STAT_LCODE = 8;                          // loop_current_code lsb

    // ************************************************************
    // Values after reset and fixed codes
    // ************************************************************
    localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h00;
    localparam logic [14:0]       THR_RST    = 15'h1000;
    localparam logic [7:0]        DRIVE_FULL = 8'hff;
    localparam logic [7:0]        DRIVE_OFF  = 8'h00;
    localparam logic [3:0]        LCODE_LINE = 4'hf;
    localparam logic [3:0]        LCODE_NONE = 4'h0;
    localparam logic [15:0]       NEG_FULL   = 16'h8000;
    localparam int                WORD_W     = 16;
    localparam int                PIN_W      = 4;

    // Sampled pin vector positions
    localparam int PIN_OVER = 0;
    localparam int PIN_SAG  = 1;
    localparam int PIN_OVL  = 2;
    localparam int PIN_LINE = 3;

    typedef enum logic {LEMC_IDLE, LEMC_SHIFT} lemc_tx_state_t;

endpackage

// file: hw/lemc_word_if.sv
/*
 * Carries the monitor word from the control core to the link serializer.
 * Both ends run on the system clock.
 */
`timescale 1ns/1ns
interface lemc_word_if;
    logic [15:0] word;
    logic        valid;
    modport src (output word, output valid);
    modport snk (input word, input valid);
endinterface

// file: hw/lemc_link_tx.sv
/*
 * Serializer of monitor samples onto the link data-in pin.
 * Assumes bit clock and frame sync arrive from the controller, asynchronous.
 */
`timescale 1ns/1ns
module lemc_link_tx
    import lemc_pkg::*;
(
    input  wire logic   i_clk_sys,
    input  wire logic   i_srst,
    input  wire logic   i_bit_clk,
    input  wire logic   i_sync,
    lemc_word_if.snk    word_if,
    output logic        o_sdata_in
);

    // ************************************************************
    // Pin synchronisers and bit clock edge detection
    // ************************************************************
    logic           bclk_meta_q, bclk_q, bclk_prev_q;
    logic           sync_meta_q, sync_q, sync_last_q;
    logic           tick;
    lemc_tx_state_t state_q;
    logic [15:0]    sreg_q;
    logic [3:0]     bit_cnt_q;

    // Two flops before any logic looks at the pins
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            bclk_meta_q <= 1'b0;
            bclk_q      <= 1'b0;
            bclk_prev_q <= 1'b0;
            sync_meta_q <= 1'b0;
            sync_q      <= 1'b0;
        end else begin
            bclk_meta_q <= i_bit_clk;
            bclk_q      <= bclk_meta_q;
            bclk_prev_q <= bclk_q;
            sync_meta_q <= i_sync;
            sync_q      <= sync_meta_q;
        end
    end

    assign tick = bclk_q & ~bclk_prev_q;

    // ************************************************************
    // Frame shifter, msb first from the rising edge after sync rises
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sync_last_q <= 1'b0;
            state_q     <= LEMC_IDLE;
            sreg_q      <= 16'h0000;
            bit_cnt_q   <= 4'h0;
            o_sdata_in  <= 1'b0;
        end else if (tick) begin
            sync_last_q <= sync_q;
            if (sync_q && !sync_last_q) begin
                // Idle monitor sends a zero word rather than stale data
                sreg_q     <= word_if.valid ? {word_if.word[14:0], 1'b0} : 16'h0000;
                o_sdata_in <= word_if.valid & word_if.word[15];
                bit_cnt_q  <= 4'h1;
                state_q    <= LEMC_SHIFT;
            end else begin
                unique case (state_q)
                    LEMC_IDLE: begin
                        o_sdata_in <= 1'b0;
                    end
                    LEMC_SHIFT: begin
                        o_sdata_in <= sreg_q[15];
                        sreg_q     <= {sreg_q[14:0], 1'b0};
                        bit_cnt_q  <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'hf) begin
                            state_q <= LEMC_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    tx_idle_low_a : assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (state_q == LEMC_IDLE && tick && !(sync_q && !sync_last_q)) |=> !o_sdata_in)
        else $error("data pin not low outside a frame");

    cover property (@(posedge i_clk_sys) disable iff (i_srst)
        state_q == LEMC_SHIFT && bit_cnt_q == 4'hf && tick);

endmodule

// file: test/lemc_link_model.sv
/*
 * Link controller model: makes the bit clock and frame sync and captures
 * one monitor word per frame. Assumes the device shifts MSB first.
 */
`timescale 1ns/1ns
module lemc_link_model (
    output logic      o_bit_clk,
    output logic      o_sync,
    input  wire logic i_sdata
);
    // Clock stands still between frames, so idle time shows no ticks
    initial begin
        o_bit_clk = 1'b0;
        o_sync    = 1'b0;
    end

    // Sync high at tick 0; bits sampled on falling ticks, mid-bit
    task automatic frame(output logic [15:0] w);
        w = 16'h0000;
        // Offset keeps link edges away from the system clock edges
        #3 o_sync = 1'b1;
        for (int i = 0; i < 16; i++) begin
            #80 o_bit_clk = 1'b1;
            #80 o_bit_clk = 1'b0;
            o_sync = 1'b0;
            w = {w[14:0], i_sdata};
        end
        // One trailing tick with sync low shows the idle level of the pin
        #80 o_bit_clk = 1'b1;
        #80 o_bit_clk = 1'b0;
    endtask
endmodule

// file: test/tb_top.sv
/*
 * Self-checking bench of the line event monitor control block.
 * Assumes the link model in its own file and the package constants.
 */
`timescale 1ns/1ns
module tb_top;
    import lemc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, over = 1'b0, sag = 1'b0, overload_level_flag = 1'b0;
    logic        line = 1'b0, sdata, bclk, sync, dcr, pwr_on, cres, ring;
    logic [15:0] smp = 16'h0000, w;
    logic [3:0]  meter = 4'h5;
    logic [7:0]  drive;
    int          bad_count = 0, total_checks = 0, cyc = 0;

    lemc_core lemc_core_inst (.i_clk_sys(clk), .i_srst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_line_over(over), .i_supply_sag(sag), .i_overload_level(overload_level_flag),
        .i_line_present(line), .i_ring_sample(smp), .i_loop_meter(meter),
        .i_bit_clk(bclk), .i_sync(sync), .o_sdata_in(sdata), .o_loop_drive(drive),
        .o_dc_release(dcr), .o_monitor_power(pwr_on), .o_coupling_reset(cres),
        .o_ring_detect(ring));
    lemc_link_model lemc_link_model_inst (.o_bit_clk(bclk), .o_sync(sync),
        .i_sdata(sdata));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial begin
        forever #5 clk = ~clk;
    end

    // Ceiling well above the few thousand cycles the tests take
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    // Request held from setup until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_bus();
        apb(1'b0, ADDR_THR, 32'h0);
        chk("thr reset", 32'h1000, r);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        chk("unmapped err", 32'h1, 32'(e));
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped data", 32'h0, r);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, r);
    endtask

    task automatic t_flags();
        over <= 1'b1;
        sag  <= 1'b1;
        repeat (4) @(posedge clk);
        over <= 1'b0;
        sag  <= 1'b0;
        apb(1'b1, ADDR_STAT, 32'h3);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("ovr sticky", 32'h1, 32'(r[STAT_OVR]));
        chk("td off", 32'h0, 32'(r[STAT_TD]));
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_TDEN);
        sag <= 1'b1; // Second event before tones are concluded
        overload_level_flag <= 1'b1;
        repeat (4) @(posedge clk);
        sag  <= 1'b0;
        over <= 1'b1;
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("td set", 32'h1, 32'(r[STAT_TD]));
        chk("ovl seen", 32'h1, 32'(r[STAT_OVL]));
        chk("dc release", 32'h1, 32'(dcr));
        // Pin drops so that only the clearing edge still sees the set
        fork
            apb(1'b1, ADDR_STAT, 32'h0);
            begin
                @(posedge clk);
                over <= 1'b0;
            end
        join
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("set beats clear", 32'h1, 32'(r[1:0]));
        chk("dc restored", 32'h0, 32'(dcr));
        over <= 1'b0;
        overload_level_flag  <= 1'b0;
        do apb(1'b0, ADDR_STAT, 32'h0); while (r[STAT_OVL] !== 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_STAT, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("flags clear", 32'h0, 32'(r[2:0]));
    endtask

    task automatic t_ring();
        smp <= 16'h2000;
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("pos flag", 32'h1, 32'(r[STAT_RPOS]));
        chk("pos detect", 32'h1, 32'(ring));
        smp <= 16'he000;
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("neg flags", 32'h2, 32'(r[STAT_RNEG:STAT_RPOS]));
        chk("half wave", 32'h0, 32'(ring));
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_FW);
        repeat (2) @(posedge clk);
        chk("full wave", 32'h1, 32'(ring));
        smp <= 16'h0000;
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_SQL);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("no flags", 32'h0, 32'(r[STAT_RNEG:STAT_RPOS]));
        chk("squelch", 32'h1, 32'(cres));
    endtask

    task automatic t_mon();
        line <= 1'b1;
        smp  <= 16'h0123;
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_MON);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("line code", 32'hf, 32'(r[STAT_LCODE+:4]));
        chk("power on", 32'h1, 32'(pwr_on));
        lemc_link_model_inst.frame(w);
        // Raw word compared; offset removal is left to the decoder
        chk("line word", 32'h0123, 32'(w));
        chk("idle pin", 32'h0, 32'(sdata));
        line <= 1'b0;
        // Pin passes two sync flops and the monitor register first
        repeat (3) @(posedge clk);
        apb(1'b0, ADDR_MON, 32'h0);
        chk("none word", 32'h8000, r);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("none code", 32'h0, 32'(r[STAT_LCODE+:4]));
        lemc_link_model_inst.frame(w);
        chk("none link", 32'h8000, 32'(w));
        apb(1'b1, ADDR_CTRL, 32'h0);
        lemc_link_model_inst.frame(w);
        chk("off link", 32'h0, 32'(w));
    endtask

    task automatic t_ramp();
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_HOOK);
        repeat (2) @(posedge clk);
        chk("off hook", 32'hff, 32'(drive));
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RAMP);
        repeat (RAMP_STEP_CYC + 500) @(posedge clk);
        chk("gradual", 32'h1, 32'(drive >= 8'hfd && drive <= 8'hfe));
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_HOOK);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("abrupt", 32'h0, 32'(drive));
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_bus();
        t_flags();
        t_ring();
        t_mon();
        t_ramp();
        summarize();
    end
endmodule
